// ===== logic/lcdreg_pkg.sv
/*
 * Shared constants of the LCD display control register slice: register
 * offsets, field positions and reset values.
 * Assumes a 16-bit register port with a 4-bit byte address.
 */
package lcdreg_pkg;
    localparam int LCDREG_AW = 4;
    localparam int LCDREG_DW = 16;

    // Register byte offsets.
    localparam logic [3:0] LCDREG_OFS_POWER = 4'h0;
    localparam logic [3:0] LCDREG_OFS_MODULE = 4'h2;
    localparam logic [3:0] LCDREG_OFS_DISPLAY = 4'h4;
    localparam logic [3:0] LCDREG_OFS_COMMON = 4'h6;
    localparam logic [3:0] LCDREG_OFS_IRQ_FLAG = 4'h8;
    localparam logic [3:0] LCDREG_OFS_IRQ_ENABLE = 4'ha;

    // Power control fields.
    localparam int LCDREG_BIT_EXT_SUPPLY = 15;
    localparam int LCDREG_BIT_REG_ENABLE = 0;
    localparam logic LCDREG_RST_EXT_SUPPLY = 1'b1;
    localparam logic LCDREG_RST_REG_ENABLE = 1'b0;

    // Module control fields.
    localparam int LCDREG_BIT_MODULE_ENABLE = 0;
    localparam logic LCDREG_RST_MODULE_ENABLE = 1'b0;

    // Display control fields.
    localparam int LCDREG_BIT_SEG_ORDER = 6;
    localparam int LCDREG_BIT_COM_ORDER = 5;
    localparam int LCDREG_BIT_POLARITY = 4;
    localparam int LCDREG_BIT_AREA = 2;
    localparam int LCDREG_BIT_MODE_HI = 1;
    localparam int LCDREG_BIT_MODE_LO = 0;
    localparam logic LCDREG_RST_SEG_ORDER = 1'b1;
    localparam logic LCDREG_RST_COM_ORDER = 1'b1;
    localparam logic LCDREG_RST_POLARITY = 1'b1;
    localparam logic LCDREG_RST_AREA = 1'b0;
    localparam logic [1:0] LCDREG_RST_MODE = 2'h0;
    localparam logic [1:0] LCDREG_MODE_OFF = 2'h0;

    // Common pin drive fields.
    localparam int LCDREG_NUM_COM = 4;
    localparam logic [3:0] LCDREG_RST_COM_DRIVE = 4'hf;

    // Interrupt fields.
    localparam int LCDREG_BIT_FRAME = 0;
    localparam logic LCDREG_RST_FRAME_FLAG = 1'b0;
    localparam logic LCDREG_RST_FRAME_IRQ_EN = 1'b0;
endpackage : lcdreg_pkg

// ===== logic/lcdreg_top.sv
/*
 * Register slice of a segment LCD driver: regulator and supply mode,
 * module enable, display control, partial common drive and frame interrupt.
 * Assumes the frame event arrives as a one-cycle pulse from logic on the
 * same clock and that the register master follows the single-cycle strobe
 * protocol with read data in the following cycle.
 */
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/1ps

module lcdreg_top
    import lcdreg_pkg::*;
(
    input wire logic I_REF_CLK,
    input wire logic I_RSTN,
    input wire logic [LCDREG_AW-1:0] I_ADDR,
    input wire logic [LCDREG_DW-1:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic I_FRAME_EVENT,
    output logic [LCDREG_DW-1:0] O_RDATA,
    output logic O_REGULATOR_ON,
    output logic O_EXT_SUPPLY_SELECT,
    output logic O_MODULE_ENABLE,
    output logic O_SEG_ORDER_NORMAL,
    output logic O_COM_ORDER_NORMAL,
    output logic O_POLARITY_NORMAL,
    output logic O_AREA_SELECT,
    output logic [1:0] O_DISPLAY_CONTROL,
    output logic [LCDREG_NUM_COM-1:0] O_COM_DRIVE_ENABLE,
    output logic O_IRQ
);
    logic wr_power;
    logic wr_module;
    logic wr_display;
    logic wr_common;
    logic wr_flag;
    logic wr_enable;
    logic module_fall;
    logic frame_flag;
    logic frame_irq_enable;
    logic [LCDREG_DW-1:0] next_rdata;

    assign wr_power = I_WR && (I_ADDR == LCDREG_OFS_POWER);
    assign wr_module = I_WR && (I_ADDR == LCDREG_OFS_MODULE);
    assign wr_display = I_WR && (I_ADDR == LCDREG_OFS_DISPLAY);
    assign wr_common = I_WR && (I_ADDR == LCDREG_OFS_COMMON);
    assign wr_flag = I_WR && (I_ADDR == LCDREG_OFS_IRQ_FLAG);
    assign wr_enable = I_WR && (I_ADDR == LCDREG_OFS_IRQ_ENABLE);
    assign module_fall = wr_module && O_MODULE_ENABLE && !I_WDATA[LCDREG_BIT_MODULE_ENABLE];

    // Supply mode and regulator; the interlock clear wins over a set in the same write.
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RSTN) begin
            O_EXT_SUPPLY_SELECT <= LCDREG_RST_EXT_SUPPLY;
            O_REGULATOR_ON <= LCDREG_RST_REG_ENABLE;
        end else if (module_fall) begin
            O_REGULATOR_ON <= 1'b0;
        end else if (wr_power) begin
            O_EXT_SUPPLY_SELECT <= I_WDATA[LCDREG_BIT_EXT_SUPPLY];
            if (I_WDATA[LCDREG_BIT_EXT_SUPPLY]) begin
                O_REGULATOR_ON <= 1'b0;
            end else begin
                O_REGULATOR_ON <= I_WDATA[LCDREG_BIT_REG_ENABLE];
            end
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (!I_RSTN) begin
            O_MODULE_ENABLE <= LCDREG_RST_MODULE_ENABLE;
        end else if (wr_module) begin
            O_MODULE_ENABLE <= I_WDATA[LCDREG_BIT_MODULE_ENABLE];
        end
    end

    // Display control; only the documented bits are stored, so reserved bits cannot be set.
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RSTN) begin
            O_SEG_ORDER_NORMAL <= LCDREG_RST_SEG_ORDER;
            O_COM_ORDER_NORMAL <= LCDREG_RST_COM_ORDER;
            O_POLARITY_NORMAL <= LCDREG_RST_POLARITY;
            O_AREA_SELECT <= LCDREG_RST_AREA;
            O_DISPLAY_CONTROL <= LCDREG_RST_MODE;
        end else if (module_fall) begin
            O_DISPLAY_CONTROL <= LCDREG_MODE_OFF;
        end else if (wr_display) begin
            O_SEG_ORDER_NORMAL <= I_WDATA[LCDREG_BIT_SEG_ORDER];
            O_COM_ORDER_NORMAL <= I_WDATA[LCDREG_BIT_COM_ORDER];
            O_POLARITY_NORMAL <= I_WDATA[LCDREG_BIT_POLARITY];
            O_AREA_SELECT <= I_WDATA[LCDREG_BIT_AREA];
            O_DISPLAY_CONTROL <= I_WDATA[LCDREG_BIT_MODE_HI:LCDREG_BIT_MODE_LO];
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < LCDREG_NUM_COM; gi++) begin : g_com
            always_ff @(posedge I_REF_CLK) begin
                if (!I_RSTN) begin
                    O_COM_DRIVE_ENABLE[gi] <= LCDREG_RST_COM_DRIVE[gi];
                end else if (wr_common) begin
                    O_COM_DRIVE_ENABLE[gi] <= I_WDATA[gi];
                end
            end
        end
    endgenerate

    // A frame event in the cycle of a clearing write keeps the flag set.
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RSTN) begin
            frame_flag <= LCDREG_RST_FRAME_FLAG;
        end else if (I_FRAME_EVENT) begin
            frame_flag <= 1'b1;
        end else if (wr_flag && I_WDATA[LCDREG_BIT_FRAME]) begin
            frame_flag <= 1'b0;
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (!I_RSTN) begin
            frame_irq_enable <= LCDREG_RST_FRAME_IRQ_EN;
        end else if (wr_enable) begin
            frame_irq_enable <= I_WDATA[LCDREG_BIT_FRAME];
        end
    end

    // The interrupt is registered, so it lags the flag by one cycle.
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RSTN) begin
            O_IRQ <= 1'b0;
        end else begin
            O_IRQ <= frame_flag && frame_irq_enable;
        end
    end

    always_comb begin
        next_rdata = '0;
        case (I_ADDR)
            LCDREG_OFS_POWER: begin
                next_rdata[LCDREG_BIT_EXT_SUPPLY] = O_EXT_SUPPLY_SELECT;
                next_rdata[LCDREG_BIT_REG_ENABLE] = O_REGULATOR_ON;
            end
            LCDREG_OFS_MODULE: begin
                next_rdata[LCDREG_BIT_MODULE_ENABLE] = O_MODULE_ENABLE;
            end
            LCDREG_OFS_DISPLAY: begin
                next_rdata[LCDREG_BIT_SEG_ORDER] = O_SEG_ORDER_NORMAL;
                next_rdata[LCDREG_BIT_COM_ORDER] = O_COM_ORDER_NORMAL;
                next_rdata[LCDREG_BIT_POLARITY] = O_POLARITY_NORMAL;
                next_rdata[LCDREG_BIT_AREA] = O_AREA_SELECT;
                next_rdata[LCDREG_BIT_MODE_HI:LCDREG_BIT_MODE_LO] = O_DISPLAY_CONTROL;
            end
            LCDREG_OFS_COMMON: begin
                next_rdata[LCDREG_NUM_COM-1:0] = O_COM_DRIVE_ENABLE;
            end
            LCDREG_OFS_IRQ_FLAG: begin
                next_rdata[LCDREG_BIT_FRAME] = frame_flag;
            end
            LCDREG_OFS_IRQ_ENABLE: begin
                next_rdata[LCDREG_BIT_FRAME] = frame_irq_enable;
            end
            default: begin
                next_rdata = '0;
            end
        endcase
    end

    // Read data stand only in the cycle after the read strobe, zero otherwise.
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RSTN) begin
            O_RDATA <= '0;
        end else if (I_RD) begin
            O_RDATA <= next_rdata;
        end else begin
            O_RDATA <= '0;
        end
    end

    default clocking cb @(posedge I_REF_CLK);
    endclocking
    default disable iff (!I_RSTN);

    regulator_on_a: assert property (wr_power && !I_WDATA[15] && I_WDATA[0] |=> O_REGULATOR_ON [*1] ##1
        (O_REGULATOR_ON || $past(I_WR)))
        else $error("regulator did not switch on");
    supply_interlock_a: assert property (wr_power && I_WDATA[15] |=> !O_REGULATOR_ON && O_EXT_SUPPLY_SELECT)
        else $error("external supply did not clear regulator enable");
    seg_order_a: assert property (wr_display |=> O_SEG_ORDER_NORMAL == $past(I_WDATA[6]))
        else $error("segment order not taken");
    com_order_a: assert property (wr_display |=> O_COM_ORDER_NORMAL == $past(I_WDATA[5]))
        else $error("common order not taken");
    polarity_a: assert property (wr_display |=> O_POLARITY_NORMAL == $past(I_WDATA[4]))
        else $error("polarity not taken");
    area_mode_a: assert property (wr_display |=> O_AREA_SELECT == $past(I_WDATA[2]) &&
        O_DISPLAY_CONTROL == $past(I_WDATA[1:0]))
        else $error("area or mode not taken");
    com_drive_a: assert property (wr_common |=> O_COM_DRIVE_ENABLE == $past(I_WDATA[3:0]))
        else $error("common drive enables not taken");
    flag_set_a: assert property (I_FRAME_EVENT |=> frame_flag)
        else $error("frame event lost");
    flag_clear_a: assert property (wr_flag && !I_FRAME_EVENT |=> frame_flag == ($past(frame_flag) &&
        !$past(I_WDATA[0])))
        else $error("frame flag clear wrong");
    irq_gate_a: assert property (frame_flag && frame_irq_enable ##1 frame_flag && frame_irq_enable |-> O_IRQ)
        else $error("unmasked flag gave no interrupt");
    irq_mask_a: assert property (!frame_irq_enable |=> !O_IRQ)
        else $error("masked flag raised interrupt");
    module_off_a: assert property (module_fall |=> O_DISPLAY_CONTROL == 2'h0 && !O_REGULATOR_ON &&
        !O_MODULE_ENABLE)
        else $error("module disable did not shut display");
    reserved_zero_a: assert property (I_RD && I_ADDR == LCDREG_OFS_DISPLAY |=> O_RDATA[15:7] == 9'h000 &&
        !O_RDATA[3])
        else $error("reserved display bits not zero");

    // The regulator only turns on under internal supply, so the two power fields are never both set.
    reg_off_a: assert property (wr_power && !I_WDATA[LCDREG_BIT_REG_ENABLE] |=> !O_REGULATOR_ON)
        else $error("regulator did not switch off");
    reg_hold_a: assert property (!wr_power && !module_fall |=> $stable(O_REGULATOR_ON))
        else $error("regulator changed without a write");
    supply_take_a: assert property (wr_power |=>
        O_EXT_SUPPLY_SELECT == $past(I_WDATA[LCDREG_BIT_EXT_SUPPLY]))
        else $error("supply mode not taken");
    supply_hold_a: assert property (!wr_power |=> $stable(O_EXT_SUPPLY_SELECT))
        else $error("supply mode changed without a write");
    supply_exclusive_a: assert property (O_EXT_SUPPLY_SELECT |-> !O_REGULATOR_ON)
        else $error("regulator on in external supply mode");

    // Every field holds between writes; the only other mover is the shutdown forced by a module disable.
    display_hold_a: assert property (!wr_display |=> $stable(O_SEG_ORDER_NORMAL) &&
        $stable(O_COM_ORDER_NORMAL) && $stable(O_POLARITY_NORMAL) && $stable(O_AREA_SELECT))
        else $error("display bits changed without a write");
    mode_hold_a: assert property (!wr_display && !module_fall |=> $stable(O_DISPLAY_CONTROL))
        else $error("display mode changed without a write");
    com_hold_a: assert property (!wr_common |=> $stable(O_COM_DRIVE_ENABLE))
        else $error("common drive changed without a write");
    module_hold_a: assert property (!wr_module |=> $stable(O_MODULE_ENABLE))
        else $error("module enable changed without a write");
    module_take_a: assert property (wr_module |=>
        O_MODULE_ENABLE == $past(I_WDATA[LCDREG_BIT_MODULE_ENABLE]))
        else $error("module enable not taken");

    // The flag moves only on an event or a clearing write; the interrupt trails it by one registered cycle.
    flag_keep_a: assert property (frame_flag && !wr_flag |=> frame_flag)
        else $error("frame flag dropped without a clear");
    flag_quiet_a: assert property (!frame_flag && !I_FRAME_EVENT |=> !frame_flag)
        else $error("frame flag set without an event");
    frame_clear_a: assert property (wr_flag && I_WDATA[LCDREG_BIT_FRAME] && !I_FRAME_EVENT |=>
        !frame_flag)
        else $error("frame flag not cleared");
    irq_idle_a: assert property (!frame_flag |=> !O_IRQ)
        else $error("interrupt without a frame flag");
    irq_rise_a: assert property (frame_flag && frame_irq_enable |=> O_IRQ)
        else $error("interrupt did not rise");
    irq_level_a: assert property (O_IRQ |-> $past(frame_flag) && $past(frame_irq_enable))
        else $error("interrupt without an unmasked flag");
    enable_take_a: assert property (wr_enable |=> frame_irq_enable == $past(I_WDATA[LCDREG_BIT_FRAME]))
        else $error("interrupt enable not taken");

    // Read data stand for exactly one cycle and carry zeros in every reserved or unmapped position.
    flag_read_a: assert property (I_RD && I_ADDR == LCDREG_OFS_IRQ_FLAG |=>
        O_RDATA == {15'h0000, $past(frame_flag)})
        else $error("frame flag read back wrong");
    enable_read_a: assert property (I_RD && I_ADDR == LCDREG_OFS_IRQ_ENABLE |=>
        O_RDATA == {15'h0000, $past(frame_irq_enable)})
        else $error("interrupt enable read back wrong");
    module_read_a: assert property (I_RD && I_ADDR == LCDREG_OFS_MODULE |=>
        O_RDATA == {15'h0000, $past(O_MODULE_ENABLE)})
        else $error("module enable read back wrong");
    power_read_a: assert property (I_RD && I_ADDR == LCDREG_OFS_POWER |=>
        O_RDATA == {$past(O_EXT_SUPPLY_SELECT), 14'h0000, $past(O_REGULATOR_ON)})
        else $error("power control read back wrong");
    disp_read_a: assert property (I_RD && I_ADDR == LCDREG_OFS_DISPLAY |=>
        O_RDATA[6:0] == {$past(O_SEG_ORDER_NORMAL), $past(O_COM_ORDER_NORMAL), $past(O_POLARITY_NORMAL), 1'b0,
        $past(O_AREA_SELECT), $past(O_DISPLAY_CONTROL)})
        else $error("display control read back wrong");
    common_read_a: assert property (I_RD && I_ADDR == LCDREG_OFS_COMMON |=>
        O_RDATA == {12'h000, $past(O_COM_DRIVE_ENABLE)})
        else $error("common drive read back wrong");
    unmapped_read_a: assert property (I_RD && (I_ADDR[0] || I_ADDR[3:2] == 2'h3) |=> O_RDATA == 16'h0000)
        else $error("unmapped address read nonzero");
    rdata_idle_a: assert property (!I_RD |=> O_RDATA == 16'h0000)
        else $error("read data outside a read cycle");

    frame_irq_c: cover property (I_FRAME_EVENT && frame_irq_enable ##2 O_IRQ);
    set_beats_clear_c: cover property (I_FRAME_EVENT && wr_flag && I_WDATA[0]);
    module_fall_c: cover property (O_DISPLAY_CONTROL != 2'h0 && module_fall);
    interlock_c: cover property (O_REGULATOR_ON && wr_power && I_WDATA[15]);
    flag_zero_write_c: cover property (frame_flag && wr_flag && !I_WDATA[0]);
endmodule : lcdreg_top

// ===== verif/tb_top.sv
/*
 * Self-checking bench of the LCD display control register slice.
 * Assumes the single-cycle strobe register port and a one-cycle frame event pulse.
 */
`timescale 1ns/1ps

module tb_top;
    import lcdreg_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic frame_ev = 1'b0;
    logic [15:0] rdata;
    logic reg_on, ext_sel, mod_en, seg_n, com_n, pol_n, area;
    logic [1:0] disp;
    logic [3:0] com_drv;
    logic irq;
    int err_total = 0;
    int check_count = 0;

    always #20 clk = ~clk;

    lcdreg_top uut (.I_REF_CLK(clk), .I_RSTN(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr_s),
        .I_RD(rd_s), .I_FRAME_EVENT(frame_ev), .O_RDATA(rdata), .O_REGULATOR_ON(reg_on),
        .O_EXT_SUPPLY_SELECT(ext_sel), .O_MODULE_ENABLE(mod_en), .O_SEG_ORDER_NORMAL(seg_n),
        .O_COM_ORDER_NORMAL(com_n), .O_POLARITY_NORMAL(pol_n), .O_AREA_SELECT(area),
        .O_DISPLAY_CONTROL(disp), .O_COM_DRIVE_ENABLE(com_drv), .O_IRQ(irq));

    // Expected register image after a write; reserved bits never stick.
    function automatic logic [15:0] exp_of(input logic [3:0] a, input logic [15:0] d);
        logic [15:0] e;
        case (a)
            4'h0: e = d & 16'h8001;
            4'h4: e = d & 16'h0077;
            4'h6: e = d & 16'h000f;
            4'ha: e = d & 16'h0001;
            default: e = 16'h0;
        endcase
        if (a == 4'h0 && d[15]) e[0] = 1'b0;
        return e;
    endfunction : exp_of

    // Output ports arranged in the layout of the register they mirror.
    function automatic logic [15:0] port_img(input logic [3:0] a);
        case (a)
            4'h0: return {ext_sel, 14'h0, reg_on};
            4'h2: return {15'h0, mod_en};
            4'h4: return {9'h0, seg_n, com_n, pol_n, 1'b0, area, disp};
            default: return {12'h0, com_drv};
        endcase
    endfunction : port_img

    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD at %0t: %0s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk_val

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        wr_s <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask : wr

    // Reads back a register and, where ports mirror it, checks those too.
    task automatic chk_reg(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        rd_s <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        chk_val(rdata, e, "read data");
        if (a <= 4'h6) chk_val(port_img(a), e, "port image");
        @(posedge clk);
        #1;
        chk_val(rdata, 16'h0000, "read data after read cycle");
    endtask : chk_reg

    task automatic pulse_frame();
        @(posedge clk);
        frame_ev <= 1'b1;
        @(posedge clk);
        frame_ev <= 1'b0;
    endtask : pulse_frame

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : finish_test

    initial begin
        #200000;
        err_total++;
        $display("BAD at %0t: watchdog expired", $time);
        finish_test();
    end

    initial begin
        logic [3:0] a;
        logic [15:0] d;
        void'($urandom(32'hfdbc1b97));
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        chk_reg(4'h0, 16'h8000);
        chk_reg(4'h2, 16'h0000);
        chk_reg(4'h4, 16'h0070);
        chk_reg(4'h6, 16'h000f);
        chk_reg(4'h8, 16'h0000);
        chk_reg(4'ha, 16'h0000);
        $display("test reset_values done");
        for (int i = 0; i < 40; i++) begin
            case (i % 4)
                0: a = 4'h0;
                1: a = 4'h4;
                2: a = 4'h6;
                default: a = 4'ha;
            endcase
            d = (i < 4) ? 16'hffff : 16'($urandom);
            wr(a, d);
            chk_reg(a, exp_of(a, d));
        end
        wr(4'hc, 16'hffff);
        chk_reg(4'hc, 16'h0000);
        $display("test random_access done");
        // Internal generation is chosen before the regulator goes on.
        wr(4'h0, 16'h0000);
        wr(4'h0, 16'h0001);
        chk_reg(4'h0, 16'h0001);
        wr(4'h0, 16'h8001);
        chk_reg(4'h0, 16'h8000);
        wr(4'h0, 16'h0001);
        wr(4'h2, 16'h0001);
        chk_reg(4'h2, 16'h0001);
        wr(4'h4, 16'h0073);
        chk_reg(4'h4, 16'h0073);
        wr(4'h2, 16'h0000);
        chk_reg(4'h4, 16'h0070);
        chk_reg(4'h0, 16'h0000);
        chk_reg(4'h2, 16'h0000);
        $display("test supply_and_module done");
        wr(4'h8, 16'h0001);
        wr(4'ha, 16'h0001);
        pulse_frame();
        @(posedge clk);
        #1;
        chk_val({15'h0, irq}, 16'h0001, "irq raised");
        chk_reg(4'h8, 16'h0001);
        wr(4'h8, 16'hfffe);
        chk_reg(4'h8, 16'h0001);
        wr(4'h8, 16'h0001);
        chk_reg(4'h8, 16'h0000);
        chk_val({15'h0, irq}, 16'h0000, "irq after clear");
        wr(4'ha, 16'h0000);
        pulse_frame();
        repeat (3) @(posedge clk);
        #1;
        chk_val({15'h0, irq}, 16'h0000, "irq masked");
        wr(4'ha, 16'h0001);
        repeat (2) @(posedge clk);
        #1;
        chk_val({15'h0, irq}, 16'h0001, "irq unmasked");
        // A frame event in the very cycle of a clearing write must survive it.
        wr(4'h8, 16'h0001);
        fork
            pulse_frame();
            wr(4'h8, 16'h0001);
        join
        chk_reg(4'h8, 16'h0001);
        wr(4'h8, 16'h0001);
        chk_reg(4'h8, 16'h0000);
        $display("test frame_interrupt done");
        wr(4'h4, 16'h0004);
        wr(4'h6, 16'h0000);
        wr(4'h0, 16'h0001);
        pulse_frame();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        chk_reg(4'h0, 16'h8000);
        chk_reg(4'h4, 16'h0070);
        chk_reg(4'h6, 16'h000f);
        chk_reg(4'h8, 16'h0000);
        chk_reg(4'ha, 16'h0000);
        chk_val({15'h0, irq}, 16'h0000, "irq after reset");
        $display("test mid_reset done");
        finish_test();
    end
endmodule : tb_top
